/* include/sfr_pkg.sv */
// Shared constants and types for the serial flash status and configuration register block.
package sfr_pkg;

   // Command opcodes seen on the serial link.
   localparam logic [7:0] OP_NOP     = 8'h00;
   localparam logic [7:0] OP_RST_EN  = 8'h66;
   localparam logic [7:0] OP_RST_MEM = 8'h99;
   localparam logic [7:0] OP_R27     = 8'h27;
   localparam logic [7:0] OP_ID      = 8'h90;
   localparam logic [7:0] OP_WRITE_UNLOCK_CMD    = 8'h06;
   localparam logic [7:0] OP_WRDI    = 8'h04;
   localparam logic [7:0] OP_REGISTER_WRITE_CMD    = 8'h01;
   localparam logic [7:0] OP_RDSR    = 8'h05;
   localparam logic [7:0] OP_RDCR    = 8'h15;
   localparam logic [7:0] OP_PP      = 8'h12;
   localparam logic [7:0] OP_SE      = 8'h21;
   localparam logic [7:0] OP_WIPE_BLOCK_32K   = 8'h5c;
   localparam logic [7:0] OP_BE      = 8'hdc;
   localparam logic [7:0] OP_CE      = 8'h60;

   // Status and configuration field positions.
   localparam int SR_WIP  = 0;
   localparam int SR_WEL  = 1;
   localparam int SR_BP   = 2;
   localparam int SR_QE   = 6;
   localparam int SR_RSVD = 7;
   localparam int CR_DS   = 0;
   localparam int CR_TB   = 3;
   localparam int CR_PBE  = 4;
   localparam int CR_DC   = 6;

   // Values after reset.
   localparam logic [3:0] BP_RST = 4'h0;
   localparam logic [2:0] DS_RST = 3'h7;
   localparam logic [1:0] DC_RST = 2'h0;
   localparam logic [7:0] SR_RST = 8'h40;
   localparam logic [7:0] CR_RST = 8'h07;

   // Identification codes; the values are arbitrary.
   localparam logic [7:0] MFR_CODE = 8'h5a;
   localparam logic [7:0] DEV_CODE = 8'ha5;
   localparam logic [7:0] ID_ADDR_DEV = 8'h01;
   // Pattern driven in dummy cycles and data filler.
   localparam logic [7:0] PREAMBLE = 8'h34;
   localparam logic [7:0] FILL     = 8'hff;

   // Frame layout counts.
   localparam logic [2:0] BYTE_END  = 3'h7;
   localparam logic [2:0] QUAD_END  = 3'h4;
   localparam logic [2:0] BIT_STEP  = 3'h1;
   localparam logic [2:0] QUAD_STEP = 3'h4;
   localparam logic [3:0] IDX_OP    = 4'h0;
   localparam logic [3:0] IDX_ID_AD = 4'h3;
   localparam logic [3:0] IDX_AD_END = 4'h4;
   localparam logic [3:0] IDX_MAX   = 4'hf;
   localparam logic [2:0] NB_SR     = 3'h2;
   localparam logic [2:0] NB_CR     = 3'h3;
   localparam logic [2:0] NB_ADDR   = 3'h5;
   localparam logic [2:0] NB_MAX    = 3'h7;
   localparam int ADDR_HI_LSB = 22;

   // Busy times and their cycle counts at the 40 ns clock.
   localparam int CLK_NS     = 40;
   localparam int T_REGISTER_WRITE_CMD_NS  = 2000;
   localparam int T_PROG_NS  = 4000;
   localparam int T_ERASE_NS = 8000;
   localparam logic [15:0] C_REGISTER_WRITE_CMD  = 16'((T_REGISTER_WRITE_CMD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] C_PROG  = 16'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] C_ERASE = 16'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] TIMER_ONE = 16'h0001;

   // Kind of the running write cycle.
   typedef enum logic [1:0] {
      K_NONE  = 2'b00,
      K_REGISTER_WRITE_CMD  = 2'b01,
      K_ARRAY = 2'b10
   } sfr_kind_t;

   // Core state on the system clock.
   typedef struct packed {
      logic        cs_q1;
      logic        cs_q2;
      logic        cs_prev;
      logic        tg_q1;
      logic        tg_q2;
      logic        tg_prev;
      logic        qm_q1;
      logic        qm_q2;
      logic [7:0]  op;
      logic [15:0] data;
      logic [31:0] addr;
      logic [2:0]  nbytes;
      logic        armed;
      logic        write_in_progress;
      logic        write_enable_latch;
      logic [3:0]  bp;
      logic        tb;
      logic [2:0]  ds;
      logic        preamble_enable;
      logic [1:0]  dc;
      sfr_kind_t   kind;
      logic [15:0] timer;
      logic [7:0]  pend_sr;
      logic [7:0]  pend_cr;
      logic        pend_cr_ok;
      logic [7:0]  snap_sr;
      logic [7:0]  snap_cr;
      logic        snap_quad;
   } sfr_core_t;

   localparam sfr_core_t CORE_RST = '{cs_q1: 1'b1, cs_q2: 1'b1, cs_prev: 1'b1, ds: DS_RST, kind: K_NONE,
                                     snap_sr: SR_RST, snap_cr: CR_RST, default: '0};

   // Link state on the serial clock.
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [3:0] idx;
      logic [7:0] sh;
      logic [7:0] op;
      logic [7:0] tx;
      logic       act;
      logic       id_dev;
   } sfr_lk_t;

   localparam sfr_lk_t LK_RST = '0;

endpackage

/* include/sfr_link_if.sv */
// Carrier between the serial link front end and the register core.
`timescale 1ns/100ps
`default_nettype none
interface sfr_link_if;
   logic [7:0] rx_byte;   // Last byte received, held for a byte slot.
   logic       rx_first;  // Byte was the opcode of its frame.
   logic       rx_tgl;    // Toggles once per received byte.
   logic [7:0] snap_sr;   // Status snapshot, frozen while a frame runs.
   logic [7:0] snap_cr;   // Configuration snapshot, frozen likewise.
   logic       snap_quad; // Quad command mode, frozen likewise.
   modport link (output rx_byte, rx_first, rx_tgl, input snap_sr, snap_cr, snap_quad);
   modport core (input rx_byte, rx_first, rx_tgl, output snap_sr, snap_cr, snap_quad);
endinterface
`default_nettype wire

/* logic/sfr_link.sv */
// Serial clock front end: shifts in command bytes and shifts out read data.
`timescale 1ns/100ps
`default_nettype none
module sfr_link
   import sfr_pkg::*;
(
   input  wire logic       sclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       cs_n_i,
   input  wire logic [3:0] io_i,
   output var  logic       so_o,
   output var  logic       so_oe_o,
   sfr_link_if.link        lk
);
   sfr_lk_t    s;            // Frame state.
   sfr_lk_t    next_s;       // Next frame state.
   logic       frame_rst_n;  // Low outside frames; the clock may stop there.
   logic       done;         // This edge completes a byte.
   logic [7:0] nb;           // Byte including this edge's bits.
   logic [7:0] cur_op;       // Opcode of the running frame.

   // Chip select high ends the frame without needing any clock edge.
   assign frame_rst_n = rst_n_i & ~cs_n_i;
   assign nb = lk.snap_quad ? {s.sh[3:0], io_i} : {s.sh[6:0], io_i[0]};
   assign done = (s.bit_cnt == (lk.snap_quad ? QUAD_END : BYTE_END));
   assign cur_op = (s.idx == IDX_OP) ? nb : s.op;

   // Byte framing and choice of the next byte to send.
   always_comb begin
      next_s = s;
      next_s.sh = nb;
      next_s.bit_cnt = s.bit_cnt + (lk.snap_quad ? QUAD_STEP : BIT_STEP);
      if (done) begin
         if (s.idx != IDX_MAX) begin
            next_s.idx = s.idx + 4'h1;
         end
         if (s.idx == IDX_OP) begin
            next_s.op = nb;
         end
         next_s.act = 1'b0;
         next_s.tx = 8'h00;
         case (cur_op)
            OP_RDSR: begin
               next_s.tx = lk.snap_sr;
               next_s.act = 1'b1;
            end
            OP_RDCR: begin
               next_s.tx = lk.snap_cr;
               next_s.act = 1'b1;
            end
            OP_ID: begin
               // The address byte picks which code goes out first.
               if (s.idx == IDX_ID_AD) begin
                  next_s.id_dev = (nb == ID_ADDR_DEV);
                  next_s.tx = (nb == ID_ADDR_DEV) ? DEV_CODE : MFR_CODE;
                  next_s.act = 1'b1;
               end else if (s.idx > IDX_ID_AD) begin
                  next_s.id_dev = ~s.id_dev;
                  next_s.tx = s.id_dev ? MFR_CODE : DEV_CODE;
                  next_s.act = 1'b1;
               end
            end
            OP_R27: begin
               // Four address bytes, then one byte slot of eight dummy clocks, then data.
               if (s.idx == IDX_AD_END) begin
                  next_s.tx = lk.snap_cr[CR_PBE] ? PREAMBLE : 8'h00;
                  next_s.act = lk.snap_cr[CR_PBE];
               end else if (s.idx > IDX_AD_END) begin
                  next_s.tx = FILL;
                  next_s.act = 1'b1;
               end
            end
            default: begin
               next_s.act = 1'b0;
            end
         endcase
         // Quad frames carry single-byte commands only, so nothing is sent back.
         if (lk.snap_quad) begin
            next_s.act = 1'b0;
         end
      end
   end

   // Frame state register, cleared whenever chip select is high.
   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         s <= LK_RST;
      end else begin
         s <= next_s;
      end
   end

   // Byte hand-off; the toggle survives frame ends so no edge is invented.
   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lk.rx_byte <= 8'h00;
         lk.rx_first <= 1'b0;
         lk.rx_tgl <= 1'b0;
      end else if (done) begin
         lk.rx_byte <= nb;
         lk.rx_first <= (s.idx == IDX_OP);
         lk.rx_tgl <= ~lk.rx_tgl;
      end
   end

   // Output data changes on the falling edge, most significant bit first.
   always_ff @(negedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
      end else begin
         so_o <= s.tx[BYTE_END - s.bit_cnt];
         so_oe_o <= s.act;
      end
   end
endmodule
`default_nettype wire

/* logic/sfr_core.sv */
// Status and configuration register core of a serial flash, with its reset command pair.
// Functional notes
// - Opcodes 00, 66, 99 reset group, enable first.
// - Other opcode after reset enable disarms it.
// - Opcode 27: four address bytes, eight dummies, data.
// - ID read address 00/01 picks first code.
// - Write in progress shows running write cycle.
// - Write unlock sets the write enable latch.
// - Program or erase ignored without enable latch.
// - Finished program or erase clears enable latch.
// - Protected target rejected, enable latch cleared.
// - Protect level bits written only by register write.
// - Whole erase only when protect level zero.
// - Quad enable reads one, bit seven reserved.
// - Drive strength field written by register write.
// - Top/bottom one-time bit selects protect origin.
// - Preamble enable drives pattern in dummy cycles.
// - Dummy count select field; config bit five reserved.
// - New configuration applies after write completes.
`timescale 1ns/100ps
`default_nettype none
module sfr_core
   import sfr_pkg::*;
(
   input  wire logic       mclk_i,                  // System clock, 25 MHz.
   input  wire logic       rst_n_i,                 // Asynchronous reset, active low.
   input  wire logic       sclk_i,                  // Serial clock from the host.
   input  wire logic       cs_n_i,                  // Chip select, active low.
   input  wire logic [3:0] io_i,                    // Serial inputs; bit 0 in single-line mode.
   input  wire logic       quad_mode_i,             // High selects quad command mode.
   output var  logic       so_o,                    // Serial data out.
   output var  logic       so_oe_o,                 // Drive enable for serial data out.
   output var  logic       write_in_progress_o,     // Busy with a write cycle.
   output var  logic       write_enable_latch_o,    // Write enable latch.
   output var  logic [3:0] protect_level_o,         // Protect level bits.
   output var  logic [2:0] drive_strength_o,        // Output driver level.
   output var  logic       top_bottom_select_o,     // Protect origin, 1 = bottom.
   output var  logic       preamble_enable_o,       // Preamble in dummy cycles.
   output var  logic [1:0] dummy_count_select_o     // Dummy clock selection.
);
   sfr_core_t  s;        // All core state.
   sfr_core_t  next_s;   // Next core state.
   logic       byte_ev;  // A new byte arrived from the link.
   logic       frame_end;// Chip select just went high.
   logic       exec;     // Run the frame's command now.
   logic       arr_op;   // Opcode programs or erases the array.
   logic       prot;     // Captured address is in the protected region.
   logic [3:0] hi;       // Top address nibble used for protection.
   logic [7:0] sr_val;   // Live status value.
   logic [7:0] cr_val;   // Live configuration value.

   sfr_link_if lk ();

   // Serial clock logic lives in its own domain.
   sfr_link u_link (
      .sclk_i  (sclk_i),
      .rst_n_i (rst_n_i),
      .cs_n_i  (cs_n_i),
      .io_i    (io_i),
      .so_o    (so_o),
      .so_oe_o (so_oe_o),
      .lk      (lk)
   );

   // Snapshots change only while no frame runs, so the link never sees them move.
   assign lk.snap_sr = s.snap_sr;
   assign lk.snap_cr = s.snap_cr;
   assign lk.snap_quad = s.snap_quad;

   // Quad enable always reads one and the reserved bits read zero.
   assign sr_val = {1'b0, 1'b1, s.bp, s.write_enable_latch, s.write_in_progress};
   assign cr_val = {s.dc, 1'b0, s.preamble_enable, s.tb, s.ds};

   // Edge detection only looks at second synchroniser stages.
   assign byte_ev = s.tg_q2 ^ s.tg_prev;
   assign frame_end = s.cs_q2 & ~s.cs_prev;
   assign exec = frame_end & ~s.write_in_progress;

   // Array-changing opcodes; all but whole erase share one gating path.
   assign arr_op = (s.op == OP_PP) || (s.op == OP_SE) || (s.op == OP_WIPE_BLOCK_32K) ||
                   (s.op == OP_BE) || (s.op == OP_CE);

   // The level protects that many sixteenths from the top, or from the bottom.
   assign hi = s.addr[ADDR_HI_LSB +: 4];
   assign prot = (s.bp != BP_RST) && (s.tb ? (hi < s.bp) : (hi > ~s.bp));

   // Whole next-state computation.
   always_comb begin
      next_s = s;
      // Two flops each for chip select, the byte toggle and quad mode.
      next_s.cs_q1 = cs_n_i;
      next_s.cs_q2 = s.cs_q1;
      next_s.cs_prev = s.cs_q2;
      next_s.tg_q1 = lk.rx_tgl;
      next_s.tg_q2 = s.tg_q1;
      next_s.tg_prev = s.tg_q2;
      next_s.qm_q1 = quad_mode_i;
      next_s.qm_q2 = s.qm_q1;

      // Running write cycle; busy reads one until the count runs out.
      if (s.write_in_progress) begin
         if (s.timer == TIMER_ONE) begin
            next_s.timer = 16'h0000;
            next_s.write_in_progress = 1'b0;
            next_s.write_enable_latch = 1'b0;
            next_s.kind = K_NONE;
            case (s.kind)
               K_REGISTER_WRITE_CMD: begin
                  // Settings take effect only once the write is complete.
                  next_s.bp = s.pend_sr[SR_BP +: 4];
                  if (s.pend_cr_ok) begin
                     next_s.ds = s.pend_cr[CR_DS +: 3];
                     next_s.tb = s.tb | s.pend_cr[CR_TB];
                     next_s.preamble_enable = s.pend_cr[CR_PBE];
                     next_s.dc = s.pend_cr[CR_DC +: 2];
                  end
               end
               K_ARRAY: begin
                  next_s.kind = K_NONE;
               end
               default: begin
                  next_s.kind = K_NONE;
               end
            endcase
         end else begin
            next_s.timer = s.timer - TIMER_ONE;
         end
      end

      // Commands run at the end of their frame; a busy device ignores them.
      if (exec) begin
         case (s.op)
            OP_WRITE_UNLOCK_CMD: begin
               next_s.write_enable_latch = 1'b1;
            end
            OP_WRDI: begin
               next_s.write_enable_latch = 1'b0;
            end
            OP_REGISTER_WRITE_CMD: begin
               if (s.write_enable_latch && (s.nbytes >= NB_SR)) begin
                  next_s.pend_sr = (s.nbytes == NB_SR) ? s.data[7:0] : s.data[15:8];
                  next_s.pend_cr = s.data[7:0];
                  next_s.pend_cr_ok = (s.nbytes >= NB_CR);
                  next_s.write_in_progress = 1'b1;
                  next_s.kind = K_REGISTER_WRITE_CMD;
                  next_s.timer = C_REGISTER_WRITE_CMD;
               end
            end
            OP_CE: begin
               // Whole-array erase needs every protect level bit at zero.
               if (s.write_enable_latch) begin
                  if (s.bp != BP_RST) begin
                     next_s.write_enable_latch = 1'b0;
                  end else begin
                     next_s.write_in_progress = 1'b1;
                     next_s.kind = K_ARRAY;
                     next_s.timer = C_ERASE;
                  end
               end
            end
            default: begin
               // Without the latch, program and erase are dropped silently.
               if (arr_op && s.write_enable_latch && (s.nbytes >= NB_ADDR)) begin
                  if (prot) begin
                     next_s.write_enable_latch = 1'b0;
                  end else begin
                     next_s.write_in_progress = 1'b1;
                     next_s.kind = K_ARRAY;
                     next_s.timer = (s.op == OP_PP) ? C_PROG : C_ERASE;
                  end
               end
            end
         endcase
      end

      // Byte intake; the reset pair acts on its opcode byte alone.
      if (byte_ev) begin
         if (lk.rx_first) begin
            next_s.op = lk.rx_byte;
            next_s.nbytes = 3'h1;
            next_s.data = 16'h0000;
            if (lk.rx_byte == OP_RST_EN) begin
               next_s.armed = 1'b1;
            end else begin
               // Any other opcode, the no-operation one included, disarms.
               next_s.armed = 1'b0;
               if ((lk.rx_byte == OP_RST_MEM) && s.armed) begin
                  // Volatile bits go to defaults; protect and top/bottom stay.
                  next_s.write_enable_latch = 1'b0;
                  next_s.write_in_progress = 1'b0;
                  next_s.timer = 16'h0000;
                  next_s.kind = K_NONE;
                  next_s.ds = DS_RST;
                  next_s.preamble_enable = 1'b0;
                  next_s.dc = DC_RST;
               end
            end
         end else begin
            next_s.data = {s.data[7:0], lk.rx_byte};
            if (s.nbytes == (NB_ADDR - 3'h1)) begin
               next_s.addr = {s.addr[23:0], lk.rx_byte};
            end else if (s.nbytes < NB_ADDR) begin
               next_s.addr = {s.addr[23:0], lk.rx_byte};
            end
            if (s.nbytes != NB_MAX) begin
               next_s.nbytes = s.nbytes + 3'h1;
            end
         end
      end

      // Refresh snapshots only between frames.
      if (s.cs_q2) begin
         next_s.snap_sr = sr_val;
         next_s.snap_cr = cr_val;
         next_s.snap_quad = s.qm_q2;
      end
   end

   // One register for the whole state.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= CORE_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs are fields of the state register.
   assign write_in_progress_o = s.write_in_progress;
   assign write_enable_latch_o = s.write_enable_latch;
   assign protect_level_o = s.bp;
   assign drive_strength_o = s.ds;
   assign top_bottom_select_o = s.tb;
   assign preamble_enable_o = s.preamble_enable;
   assign dummy_count_select_o = s.dc;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence seq_arm;
      byte_ev && lk.rx_first && (lk.rx_byte == OP_RST_EN);
   endsequence
   sequence seq_fire;
      byte_ev && lk.rx_first && (lk.rx_byte == OP_RST_MEM) && s.armed && !s.write_in_progress;
   endsequence
   sequence seq_volatile_dflt;
      !s.write_enable_latch && !s.write_in_progress && (s.ds == DS_RST) && !s.preamble_enable && (s.dc == DC_RST);
   endsequence

   AST_ARM: assert property (seq_arm |=> s.armed)
      else $error("Reset enable did not arm.");
   AST_DISARM: assert property (byte_ev && lk.rx_first && (lk.rx_byte != OP_RST_EN) |=> !s.armed)
      else $error("Reset stayed armed after another opcode.");
   AST_RST_MEM: assert property (seq_fire |=> seq_volatile_dflt and $stable(s.tb) and $stable(s.bp))
      else $error("Reset memory left wrong register values.");
   AST_QE_ONE: assert property (lk.snap_sr[SR_QE] && !lk.snap_sr[SR_RSVD] && !lk.snap_cr[5])
      else $error("Fixed status or reserved bits wrong.");
   AST_WEL_SET: assert property (exec && (s.op == OP_WRITE_UNLOCK_CMD) |=> s.write_enable_latch)
      else $error("Write unlock did not set the latch.");
   AST_NO_WEL: assert property (exec && arr_op && !s.write_enable_latch |=> !s.write_in_progress)
      else $error("Array command ran without the latch.");
   AST_WEL_DONE: assert property ($fell(s.write_in_progress) |-> !s.write_enable_latch)
      else $error("Latch still set after write cycle end.");
   AST_PROT: assert property (exec && arr_op && (s.op != OP_CE) && s.write_enable_latch && prot && (s.nbytes >= NB_ADDR)
                              |=> !s.write_in_progress && !s.write_enable_latch)
      else $error("Protected target was not rejected.");
   AST_CE_LOCK: assert property (exec && (s.op == OP_CE) && (s.bp != BP_RST) |=> !s.write_in_progress && !s.write_enable_latch)
      else $error("Whole erase ran with protection set.");
   AST_CFG_HOLD: assert property (s.write_in_progress && next_s.write_in_progress |=> $stable({s.ds, s.preamble_enable, s.dc, s.bp}))
      else $error("Settings changed before write completed.");
   AST_WIP_TIME: assert property (exec && (s.op == OP_REGISTER_WRITE_CMD) && s.write_enable_latch && (s.nbytes >= NB_SR)
                                  |=> s.write_in_progress[*8] ##[1:50] !s.write_in_progress)
      else $error("Register write busy time wrong.");
endmodule
`default_nettype wire

/* verification/sfr_host.sv */
// Host controller model that frames serial commands and collects read data.
`timescale 1ns/100ps
`default_nettype none
module sfr_host (
   output var  logic       sclk_o, // Serial clock, still between frames.
   output var  logic       cs_n_o, // Chip select, active low.
   output var  logic [3:0] io_o,   // Data lines towards the device.
   input  wire logic       quad_i, // High sends two nibbles per byte.
   input  wire logic       so_i    // Data from the device.
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      io_o   = 4'h5;
   end
   // Sends bytes MSB first, then reads nrd bytes; any byte values are sent unchecked.
   task automatic frame(input logic [7:0] b[$], input int nrd, output logic [7:0] rd);
      int step;
      step = quad_i ? 4 : 1;
      rd = 8'h00;
      cs_n_o = 1'b0;
      foreach (b[i]) for (int k = 8 - step; k >= 0; k -= step) begin
         io_o = quad_i ? b[i][k +: 4] : {3'h0, b[i][k]};
         #80 sclk_o = 1'b1;
         #80 sclk_o = 1'b0;
      end
      for (int k = 0; k < nrd * 8; k++) begin
         #80 sclk_o = 1'b1;
         rd = {rd[6:0], so_i};
         #80 sclk_o = 1'b0;
      end
      #80 cs_n_o = 1'b1;
      // Lines left undriven by the frame must not keep their last value.
      io_o = ~io_o;
      #400;
   endtask
endmodule
`default_nettype wire

/* verification/sfr_core_bench.sv */
// Self-checking bench for the register core against an integer model.
`timescale 1ns/100ps
`default_nettype none
module sfr_core_bench;
   import sfr_pkg::*;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, quad = 1'b0, sclk, cs_n, so, so_oe, write_in_progress, write_enable_latch, tb, preamble_enable;
   logic [3:0] io, bp;
   logic [2:0] ds;
   logic [1:0] dc;
   logic [7:0] rd;
   int bad_count = 0, checks_done = 0;
   int m_wel = 0, m_bp = 0, m_tb = 0, m_ds = 7, m_pbe = 0, m_dc = 0; // Model state.
   always #20 mclk_i = ~mclk_i;
   sfr_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io),
      .quad_mode_i(quad), .so_o(so), .so_oe_o(so_oe), .write_in_progress_o(write_in_progress),
      .write_enable_latch_o(write_enable_latch), .protect_level_o(bp), .drive_strength_o(ds),
      .top_bottom_select_o(tb), .preamble_enable_o(preamble_enable), .dummy_count_select_o(dc));
   sfr_host host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io), .quad_i(quad), .so_i(so));
   // Compares all register outputs with the model.
   task automatic cmp_regs(input logic w);
      checks_done++;
      if ({write_in_progress, write_enable_latch, bp, ds, tb, preamble_enable, dc} !== {w, 1'(m_wel), 4'(m_bp), 3'(m_ds), 1'(m_tb), 1'(m_pbe), 2'(m_dc)}) begin
         bad_count++;
         $display("MISMATCH %0t registers %b", $time, {write_in_progress, write_enable_latch, bp, ds, tb, preamble_enable, dc});
      end
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] b[$], input int nrd);
      host.frame(b, nrd, rd);
      repeat (4) @(negedge mclk_i);
   endtask
   // Busy must show at the start of the cycle; the latch drops when it ends.
   task automatic busy(input int n);
      cmp_regs(1'b1);
      repeat (n) @(negedge mclk_i);
      m_wel = 0;
   endtask
   task automatic register_write_cmd(input logic [7:0] sr, input logic [7:0] cr);
      cmd({OP_WRITE_UNLOCK_CMD}, 0);
      m_wel = 1;
      cmp_regs(1'b0);
      cmd({OP_REGISTER_WRITE_CMD, sr, cr}, 0);
      busy(50);
      m_bp = sr[5:2];
      m_tb = m_tb | cr[3];
      m_ds = cr[2:0];
      m_pbe = cr[4];
      m_dc = cr[7:6];
      cmp_regs(1'b0);
   endtask
   initial begin
      #1_000_000;
      bad_count++;
      final_report();
   end
   initial begin
      void'($urandom(22304));
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      cmp_regs(1'b0);
      cmd({OP_RDSR}, 1);
      cmp_byte(rd, 8'h40);
      cmd({OP_PP, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
      cmp_regs(1'b0);
      $display("test defaults done");
      for (int t = 0; t < 3; t++) register_write_cmd(8'($urandom), 8'($urandom));
      register_write_cmd(8'h04, 8'h10);
      cmd({OP_RDSR}, 1);
      cmp_byte(rd, {2'b01, 4'(m_bp), 2'b00});
      cmp_byte({7'h00, so_oe}, 8'h00);
      cmd({OP_R27, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
      cmp_byte(rd, PREAMBLE);
      for (int a = 0; a < 2; a++) begin
         cmd({OP_ID, 8'h00, 8'h00, 8'(a)}, 1);
         cmp_byte(rd, a ? DEV_CODE : MFR_CODE);
      end
      $display("test register writes done");
      cmd({OP_WRITE_UNLOCK_CMD}, 0);
      cmd({OP_CE}, 0);
      cmp_regs(1'b0);
      cmd({OP_WRITE_UNLOCK_CMD}, 0);
      m_wel = 1;
      cmd({OP_PP, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
      if (m_tb == 0) busy(100);
      m_wel = 0;
      cmp_regs(1'b0);
      $display("test program and erase done");
      cmd({OP_WRITE_UNLOCK_CMD}, 0);
      m_wel = 1;
      cmd({OP_RST_EN}, 0);
      cmd({OP_NOP}, 0);
      cmd({OP_RST_MEM}, 0);
      cmp_regs(1'b0);
      quad = 1'b1;
      repeat (4) @(negedge mclk_i);
      cmd({OP_RST_EN}, 0);
      cmd({OP_RST_MEM}, 0);
      m_wel = 0;
      m_ds = 7;
      m_pbe = 0;
      m_dc = 0;
      cmp_regs(1'b0);
      $display("test reset pair done");
      final_report();
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
endmodule
`default_nettype wire
